// ==== logic/fram_link_pkg.sv ====
package fram_link_pkg;

  localparam int         BYTE_BITS      = 8;
  localparam int         ADDR_BITS      = 13;
  localparam int         ADDR_MIN_BITS  = 9;
  localparam int         ADDR_MAX_BITS  = 16;
  localparam logic [3:0] BIT_COUNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_STEP       = 4'h1;
  localparam logic [3:0] LAST_DATA_BIT  = 4'h7;
  localparam logic [3:0] ACK_SLOT       = 4'h8;
  localparam logic [1:0] SYNC_IDLE      = 2'h3;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic       LINE_LOW       = 1'b0;

  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'b000,
    ST_SLAVE   = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WRITE   = 3'b100,
    ST_READ    = 3'b101
  } link_state_type;

  typedef struct packed
  {
    logic [3:0] typeCode;
    logic [2:0] select;
    logic       readNotWrite;
  } slave_addr_type;

endpackage

// ==== logic/fram_serial_slave.sv ====
`timescale 1ns/100ps

// Notes on behaviour
// - SDA rising while SCL high is stop
// - Stop abandons any operation, returns idle
// - SDA falling while SCL high is start
// - Start aborts anything, expects slave address
// - SDA stable while SCL high; sample high
// - Ninth slot is acknowledge, receiver pulls low
// - Missing acknowledge terminates current operation
// - Read: eight bits, ack continues, nack ends
// - Slave address upper nibble must match type
// - Address bits three..one match select pins
// - Address bit zero: one read, zero write
// - Write loads two address bytes into latch
// - Latch persists; reads start at current address
// - Increment latch before ack, wrap to zero
// - All bytes travel most significant bit first
// - Write bytes acked, go to consecutive addresses
// - Array written after eighth bit, before ack
// - No write recovery; polling always acked
// - Protect high: no data ack, no increment
// - Protect low enables writes; pulled down
// - Upper three memory address bits ignored
// - Capture on SCL rise, drive after fall
// - Select pins pulled down, open reads zero
module fram_serial_slave
#(
  parameter int         ADDR_WIDTH = fram_link_pkg::ADDR_BITS,
  // Type code value is arbitrary
  parameter logic [3:0] TYPE_CODE  = 4'h6
)
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [2:0] deviceSelectPins,
  input  wire logic       writeProtect,
  output logic            busActive
);
  import fram_link_pkg::*;

  localparam int HI_BITS = ADDR_WIDTH - BYTE_BITS;
  localparam int DEPTH   = 1 << ADDR_WIDTH;
  localparam logic [ADDR_WIDTH-1:0] ADDR_STEP = ADDR_WIDTH'(1);
  localparam logic [ADDR_WIDTH-1:0] ADDR_ZERO = '0;
  localparam logic [HI_BITS-1:0]    HI_ZERO   = '0;

  generate
    if (ADDR_WIDTH < ADDR_MIN_BITS || ADDR_WIDTH > ADDR_MAX_BITS)
    begin : g_bad_width
      $error("ADDR_WIDTH out of supported range");
    end
  endgenerate

  logic [1:0]            sclSync;
  logic [1:0]            sdaSync;
  logic                  sclLast;
  logic                  sdaLast;
  logic                  startDet;
  logic                  stopDet;
  logic                  linkClear;
  logic                  linkReset;
  logic                  sdaHi;
  logic [7:0]            shiftIn;
  logic [7:0]            outShift;
  logic [2:0]            selMeta;
  logic [2:0]            selSync;
  logic                  wpMeta;
  logic                  wpSync;
  link_state_type        state;
  logic [3:0]            bitCnt;
  logic                  pullLow;
  logic                  ackGiven;
  logic                  readMode;
  logic [HI_BITS-1:0]    addrHi;
  logic [ADDR_WIDTH-1:0] addr;
  logic [7:0]            mem [DEPTH];
  logic [7:0]            rdByte;
  slave_addr_type        slaveAddr;
  logic                  match;
  logic                  startSeen;
  logic                  byteEnd;
  logic                  slotEnd;
  logic                  memWrite;
  logic                  addrIncr;
  logic                  addrLoad;

  // Bus watcher on clk: only start and stop are seen here
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      sclSync <= SYNC_IDLE;
      sdaSync <= SYNC_IDLE;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end
    else
    begin
      sclSync <= {sclSync[0], scl};
      sdaSync <= {sdaSync[0], sdaIn};
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end

  assign startDet = sclSync[1] & sclLast & sdaLast & ~sdaSync[1];
  assign stopDet  = sclSync[1] & sclLast & ~sdaLast & sdaSync[1];

  // Holds the link logic cleared between stop and start
  always_ff @(posedge clk)
  begin
    if (!nrst)
      linkClear <= 1'b1;
    else if (startDet)
      linkClear <= 1'b0;
    else if (stopDet)
      linkClear <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      linkReset <= 1'b1;
    else
      linkReset <= 1'b0;
  end

  assign busActive = ~linkClear;

  a_stop_abort: assert property (@(posedge clk) disable iff (!nrst)
    stopDet |=> linkClear && !sdaOe)
    else $error("stop did not abort the link");

  a_start_open: assert property (@(posedge clk) disable iff (!nrst)
    startDet |=> !linkClear ##1 !linkClear)
    else $error("start did not open the link");

  // Link side, rising edge: capture only
  always_ff @(posedge scl or posedge linkClear)
  begin
    if (linkClear)
    begin
      sdaHi   <= 1'b1;
      shiftIn <= BYTE_ZERO;
    end
    else
    begin
      sdaHi   <= sdaIn;
      shiftIn <= {shiftIn[6:0], sdaIn};
    end
  end

  // Static pins, still passed through two stages
  always_ff @(posedge scl or posedge linkReset)
  begin
    if (linkReset)
    begin
      selMeta <= 3'h0;
      selSync <= 3'h0;
      wpMeta  <= 1'b0;
      wpSync  <= 1'b0;
    end
    else
    begin
      selMeta <= deviceSelectPins;
      selSync <= selMeta;
      wpMeta  <= writeProtect;
      wpSync  <= wpMeta;
    end
  end

  // SDA was high at the rise and is low at the fall
  assign startSeen = sdaHi & ~sdaIn;
  assign slaveAddr = shiftIn;
  assign match     = (slaveAddr.typeCode == TYPE_CODE)
                   && (slaveAddr.select == selSync);
  assign byteEnd   = !startSeen && bitCnt == LAST_DATA_BIT;
  assign slotEnd   = !startSeen && bitCnt == ACK_SLOT;
  assign memWrite  = byteEnd && state == ST_WRITE && !wpSync;
  assign addrIncr  = memWrite || (byteEnd && state == ST_READ);
  assign addrLoad  = byteEnd && state == ST_ADDR_LO;
  assign rdByte    = mem[addr];

  // Protocol sequencer, falling edge so SDA changes while SCL is low
  always_ff @(negedge scl or posedge linkClear)
  begin
    if (linkClear)
    begin
      state    <= ST_IDLE;
      bitCnt   <= BIT_COUNT_ZERO;
      pullLow  <= 1'b0;
      ackGiven <= 1'b0;
      readMode <= 1'b0;
      addrHi   <= HI_ZERO;
      outShift <= BYTE_ZERO;
    end
    else if (startSeen)
    begin
      state    <= ST_SLAVE;
      bitCnt   <= BIT_COUNT_ZERO;
      pullLow  <= 1'b0;
      ackGiven <= 1'b0;
    end
    else if (state == ST_IDLE)
      pullLow <= 1'b0;
    else if (bitCnt == LAST_DATA_BIT)
    begin
      bitCnt <= ACK_SLOT;
      unique case (state)
        ST_SLAVE:
        begin
          ackGiven <= match;
          pullLow  <= match;
          readMode <= slaveAddr.readNotWrite;
        end
        ST_ADDR_HI:
        begin
          addrHi   <= shiftIn[HI_BITS-1:0];
          ackGiven <= 1'b1;
          pullLow  <= 1'b1;
        end
        ST_ADDR_LO:
        begin
          ackGiven <= 1'b1;
          pullLow  <= 1'b1;
        end
        ST_WRITE:
        begin
          ackGiven <= !wpSync;
          pullLow  <= !wpSync;
        end
        ST_READ:
        begin
          // Release so the master can answer
          ackGiven <= 1'b0;
          pullLow  <= 1'b0;
        end
        default:
          pullLow <= 1'b0;
      endcase
    end
    else if (bitCnt == ACK_SLOT)
    begin
      bitCnt  <= BIT_COUNT_ZERO;
      pullLow <= 1'b0;
      if (!ackGiven && state != ST_READ)
        state <= ST_IDLE;
      else
      begin
        unique case (state)
          ST_SLAVE:
            if (readMode)
            begin
              state    <= ST_READ;
              pullLow  <= ~rdByte[7];
              outShift <= {rdByte[6:0], LINE_LOW};
            end
            else
              state <= ST_ADDR_HI;
          ST_ADDR_HI:
            state <= ST_ADDR_LO;
          ST_ADDR_LO:
            state <= ST_WRITE;
          ST_WRITE:
            state <= ST_WRITE;
          ST_READ:
            if (sdaHi)
              state <= ST_IDLE;
            else
            begin
              pullLow  <= ~rdByte[7];
              outShift <= {rdByte[6:0], LINE_LOW};
            end
          default:
            state <= ST_IDLE;
        endcase
      end
    end
    else
    begin
      bitCnt <= bitCnt + BIT_STEP;
      if (state == ST_READ)
      begin
        pullLow  <= ~outShift[7];
        outShift <= {outShift[6:0], LINE_LOW};
      end
    end
  end

  // Survives stop and start; only power-on clears it
  always_ff @(negedge scl or posedge linkReset)
  begin
    if (linkReset)
      addr <= ADDR_ZERO;
    else if (addrLoad)
      addr <= {addrHi, shiftIn};
    else if (addrIncr)
      addr <= addr + ADDR_STEP;
  end

  // Nonvolatile contents, so no reset
  always_ff @(negedge scl)
  begin
    if (memWrite)
      mem[addr] <= shiftIn;
  end

  assign sdaOut = LINE_LOW;
  assign sdaOe  = pullLow;

  a_write_incr: assert property (@(negedge scl) disable iff (linkClear)
    memWrite |=> addr == $past(addr) + ADDR_STEP && sdaOe)
    else $error("write did not advance and ack");

  a_write_store: assert property (@(negedge scl)
    disable iff (linkClear)
    memWrite |=> mem[$past(addr)] == $past(shiftIn))
    else $error("written byte not stored");

  a_protect_hold: assert property (@(negedge scl)
    disable iff (linkClear)
    (byteEnd && state == ST_WRITE && wpSync)
      |=> addr == $past(addr) && !sdaOe ##1 state == ST_IDLE)
    else $error("protected write was acked or advanced");

  a_slave_ack: assert property (@(negedge scl) disable iff (linkClear)
    (byteEnd && state == ST_SLAVE) |=> sdaOe == $past(match))
    else $error("slave ack disagrees with match");

  a_read_first: assert property (@(negedge scl) disable iff (linkClear)
    (slotEnd && state == ST_SLAVE && ackGiven && readMode)
      |=> state == ST_READ && sdaOe == !$past(rdByte[7]))
    else $error("read did not start with msb");

  a_read_nack: assert property (@(negedge scl) disable iff (linkClear)
    (slotEnd && state == ST_READ && sdaHi)
      |=> state == ST_IDLE && !sdaOe)
    else $error("read continued after nack");

  a_noack_end: assert property (@(negedge scl) disable iff (linkClear)
    (slotEnd && state != ST_READ && state != ST_IDLE && !ackGiven)
      |=> state == ST_IDLE)
    else $error("operation kept after no-ack");

  a_restart_addr: assert property (@(negedge scl)
    disable iff (linkClear)
    startSeen |=> state == ST_SLAVE && bitCnt == BIT_COUNT_ZERO
      && !sdaOe)
    else $error("start did not rearm address phase");

  a_idle_quiet: assert property (@(negedge scl) disable iff (linkClear)
    (state == ST_IDLE && !startSeen) |=> !sdaOe)
    else $error("idle device drove the line");

  a_addr_load: assert property (@(negedge scl) disable iff (linkClear)
    addrLoad |=> addr == $past({addrHi, shiftIn}))
    else $error("address latch not loaded");

  a_read_incr: assert property (@(negedge scl) disable iff (linkClear)
    (byteEnd && state == ST_READ) |=> addr == $past(addr) + ADDR_STEP
      && !sdaOe)
    else $error("read byte did not advance and release");

endmodule

// ==== tb/i2c_master_model.sv ====
`timescale 1ns/100ps

module i2c_master_model
(
  output logic     scl,
  input  wire      sda,
  output logic     sdaDrive
);
  // Clock stands still between frames
  initial
  begin
    scl = 1'b1;
    sdaDrive = 1'b0;
  end

  task automatic bitx(input logic b, output logic r);
    #20 sdaDrive = ~b;
    #42.5 scl = 1'b1;
    #31 r = sda;
    #31.5 scl = 1'b0;
  endtask

  // Long hold so the slow domain sees it
  task automatic start();
    #20 sdaDrive = 1'b0;
    #40 scl = 1'b1;
    #100 sdaDrive = 1'b1;
    #250 scl = 1'b0;
  endtask

  task automatic stop();
    #20 sdaDrive = 1'b1;
    #40 scl = 1'b1;
    #100 sdaDrive = 1'b0;
    #400;
  endtask

  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic rdByte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(~more, r);
  endtask
endmodule

// ==== tb/tb_fram_serial_slave.sv ====
`timescale 1ns/100ps

module tb_fram_serial_slave;
  import fram_link_pkg::*;
  // Type nibble value is arbitrary
  localparam logic [3:0] TCODE = 4'h6;
  logic       clk;
  logic       nrst;
  logic       scl;
  logic       sdaDrive;
  logic       sdaOut;
  logic       sdaOe;
  logic [2:0] deviceSelectPins;
  logic       writeProtect;
  logic       busActive;
  wire        sda;
  int         n_mismatch;
  int         n_compared;
  logic [7:0] mem [0:8191];
  logic       ack;
  logic       r;
  logic [7:0] d;
  logic [12:0] a;

  // Pull-up: high unless the master or the enabled device pulls low
  assign sda = (sdaOe ? sdaOut : 1'b1) & ~sdaDrive;

  fram_serial_slave #(.ADDR_WIDTH(ADDR_BITS), .TYPE_CODE(TCODE)) dut
  (
    .clk(clk),
    .nrst(nrst),
    .scl(scl),
    .sdaIn(sda),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .deviceSelectPins(deviceSelectPins),
    .writeProtect(writeProtect),
    .busActive(busActive)
  );

  i2c_master_model master
  (
    .scl(scl),
    .sda(sda),
    .sdaDrive(sdaDrive)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [7:0] slaveByte(input logic rd);
    return {TCODE, deviceSelectPins, rd};
  endfunction

  task automatic cmpBit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic sendAddr(input logic [15:0] x);
    master.start();
    master.wrByte(slaveByte(1'b0), ack);
    cmpBit(ack, 1'b1);
    master.wrByte(x[15:8], ack);
    cmpBit(ack, 1'b1);
    master.wrByte(x[7:0], ack);
    cmpBit(ack, 1'b1);
  endtask

  task automatic readSeq(input int n, input logic [12:0] x,
                         input logic endStop);
    master.start();
    master.wrByte(slaveByte(1'b1), ack);
    cmpBit(ack, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      master.rdByte(i < n - 1, d);
      cmpByte(d, mem[x]);
      x++;
    end
    // Without stop, the final nack ends the read and the caller's next start follows
    if (endStop)
      master.stop();
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // About 0.12 ms of traffic expected
  initial
  begin
    #2000000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    nrst = 1'b0;
    deviceSelectPins = 3'h5;
    writeProtect = 1'b0;
    n_mismatch = 0;
    n_compared = 0;
    d = 8'($urandom(32'h8BE68336));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    master.start();
    cmpBit(busActive, 1'b1);
    master.wrByte({TCODE, 3'h2, 1'b0}, ack);
    cmpBit(ack, 1'b0);
    master.wrByte(8'($urandom), ack);
    cmpBit(ack, 1'b0);
    master.start();
    master.wrByte({~TCODE, 3'h5, 1'b0}, ack);
    cmpBit(ack, 1'b0);
    master.stop();
    cmpBit(busActive, 1'b0);
    $display("address match test done");
    for (int k = 0; k < 5; k++)
    begin
      @(negedge clk);
      deviceSelectPins = 3'($urandom_range(7));
      a = (k == 0) ? 13'h1FFE : 13'($urandom);
      sendAddr({3'($urandom), a});
      for (int i = 0; i < 3; i++)
      begin
        d = 8'($urandom);
        mem[a + 13'(i)] = d;
        master.wrByte(d, ack);
        cmpBit(ack, 1'b1);
      end
      master.stop();
      sendAddr({3'h7, a});
      readSeq(2, a, 1'b1);
      readSeq(1, a + 13'h2, 1'b1);
    end
    $display("write and read test done");
    @(negedge clk);
    writeProtect = 1'b1;
    sendAddr(16'h1FFF);
    master.wrByte(~mem[8191], ack);
    cmpBit(ack, 1'b0);
    master.wrByte(8'($urandom), ack);
    cmpBit(ack, 1'b0);
    master.stop();
    @(negedge clk);
    writeProtect = 1'b0;
    readSeq(1, 13'h1FFF, 1'b0);
    $display("protect test done");
    sendAddr(16'h0000);
    for (int i = 0; i < 4; i++)
      master.bitx(~mem[0][7 - i], r);
    readSeq(1, 13'h0000, 1'b1);
    $display("abort test done");
    final_report();
  end
endmodule
